/* pwrt_top.sv */
// Periodic wakeup timer with RC clock trim and temperature offset trim, on an AHB-Lite slave.
`timescale 1ns/1ps
`include "pwrt_defs.svh"

module pwrt_top (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        aclk_i,
	input  wire logic        special_mode_i,
	input  wire logic [5:0]  flash_rc_trim_i,
	input  wire logic [7:0]  flash_temp_trim_i,
	output logic      [5:0]  rc_period_trim_field_o,
	output logic             temp_offset_enable_o,
	output logic      [3:0]  temp_offset_trim_field_o,
	output logic      [7:0]  test_o,
	output logic             periodic_timeout_o,
	output logic             irq_o
);

	pwrt_pkg::pwrt_state_s s_r;
	pwrt_pkg::pwrt_state_s s_nxt;

	logic        wr_en;
	logic [31:0] wd;
	logic [17:0] limit;
	logic        aclk_rise;
	logic        cnt_step;
	logic        timeout;
	logic        clr_flag;
	logic        en_wr_val;

	always_comb begin
		s_nxt = s_r;
		wd = hwdata_i;
		wr_en = s_r.dp_wr;
		en_wr_val = wd[`PWRT_CTRL_ENABLE_BIT];
		clr_flag = 1'b0;
		aclk_rise = aclk_i & ~s_r.aclk_d;
		s_nxt.aclk_d = aclk_i;

		// Trim values come from flash in the first cycle after reset release.
		s_nxt.load_pend = 1'b0;
		if (s_r.load_pend) begin
			s_nxt.rc_trim = flash_rc_trim_i;
			s_nxt.temp_oe = flash_temp_trim_i[`PWRT_TEMP_OE_BIT];
			s_nxt.temp_trim = flash_temp_trim_i[`PWRT_TEMP_TRIM_MSB:0];
		end

		// Data phase of a write: the address was latched in the address phase.
		if (wr_en) begin
			case (s_r.dp_idx)
				`PWRT_IDX_CTRL: begin
					if (!s_r.enable && !en_wr_val) begin
						s_nxt.clksel = wd[`PWRT_CTRL_CLKSEL_BIT];
					end
					s_nxt.enable = en_wr_val;
				end
				`PWRT_IDX_STATUS: begin
					clr_flag = wd[`PWRT_FLAG_BIT];
				end
				`PWRT_IDX_RC_TRIM: begin
					s_nxt.rc_trim = wd[`PWRT_RC_TRIM_MSB:`PWRT_RC_TRIM_LSB];
				end
				`PWRT_IDX_RATE: begin
					if (!s_r.enable) begin
						s_nxt.rate = wd[15:0];
					end
				end
				`PWRT_IDX_MASK: begin
					s_nxt.mask = wd[`PWRT_FLAG_BIT];
				end
				`PWRT_IDX_TEST: begin
					if (special_mode_i) begin
						s_nxt.test = wd[7:0];
					end
				end
				`PWRT_IDX_TEMP_TRIM: begin
					s_nxt.temp_oe = wd[`PWRT_TEMP_OE_BIT];
					s_nxt.temp_trim = wd[`PWRT_TEMP_TRIM_MSB:0];
				end
				default: begin
				end
			endcase
		end

		// Terminal count: the RC limit is twice the bus limit plus one, and each RC tick is one timer step.
		if (s_r.clksel == `PWRT_SEL_BUS) begin
			limit = {1'b0, s_r.rate, 1'b1};
			cnt_step = 1'b1;
		end else begin
			limit = {s_r.rate, 2'b11};
			cnt_step = aclk_rise;
		end

		timeout = 1'b0;
		case (s_r.st)
			pwrt_pkg::PWRT_IDLE: begin
				s_nxt.cnt = 18'h00000;
				s_nxt.gate_cnt = 2'h0;
				if (s_r.enable) begin
					if (s_r.clksel == `PWRT_SEL_BUS) begin
						s_nxt.st = pwrt_pkg::PWRT_RUN;
					end else begin
						s_nxt.st = pwrt_pkg::PWRT_GATE;
					end
				end
			end
			pwrt_pkg::PWRT_GATE: begin
				// The RC clock gate opens after two rising RC edges, which costs one to two RC cycles.
				if (!s_r.enable) begin
					s_nxt.st = pwrt_pkg::PWRT_IDLE;
				end else if (aclk_rise) begin
					s_nxt.gate_cnt = s_r.gate_cnt + 2'h1;
					if (s_r.gate_cnt + 2'h1 == `PWRT_GATE_EDGES) begin
						s_nxt.st = pwrt_pkg::PWRT_RUN;
					end
				end
			end
			pwrt_pkg::PWRT_RUN: begin
				if (!s_r.enable) begin
					s_nxt.st = pwrt_pkg::PWRT_IDLE;
				end else if (cnt_step) begin
					if (s_r.cnt == limit) begin
						timeout = 1'b1;
						s_nxt.cnt = 18'h00000;
					end else begin
						s_nxt.cnt = s_r.cnt + 18'h00001;
					end
				end
			end
			default: begin
				s_nxt.st = pwrt_pkg::PWRT_IDLE;
			end
		endcase

		// A time-out in the same cycle as a clear leaves the flag set.
		if (timeout) begin
			s_nxt.flag = 1'b1;
		end else if (clr_flag) begin
			s_nxt.flag = 1'b0;
		end
		s_nxt.tick = timeout;
		s_nxt.irq = s_nxt.flag & s_nxt.mask;

		// Address phase: latch the access and prepare read data from the updated registers.
		s_nxt.dp_wr = 1'b0;
		s_nxt.dp_rd = 1'b0;
		s_nxt.hready = 1'b1;
		if (hsel_i && htrans_i[1] && hready_i) begin
			s_nxt.dp_wr = hwrite_i;
			s_nxt.dp_rd = ~hwrite_i;
			s_nxt.dp_idx = haddr_i[`PWRT_IDX_W+1:2];
		end
		s_nxt.hrdata = 32'h00000000;
		if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
			case (haddr_i[`PWRT_IDX_W+1:2])
				`PWRT_IDX_CTRL: begin
					s_nxt.hrdata[`PWRT_CTRL_CLKSEL_BIT] = s_nxt.clksel;
					s_nxt.hrdata[`PWRT_CTRL_ENABLE_BIT] = s_nxt.enable;
				end
				`PWRT_IDX_STATUS: begin
					s_nxt.hrdata[`PWRT_FLAG_BIT] = s_nxt.flag;
				end
				`PWRT_IDX_RC_TRIM: begin
					s_nxt.hrdata[`PWRT_RC_TRIM_MSB:`PWRT_RC_TRIM_LSB] = s_nxt.rc_trim;
				end
				`PWRT_IDX_RATE: begin
					s_nxt.hrdata[15:0] = s_nxt.rate;
				end
				`PWRT_IDX_MASK: begin
					s_nxt.hrdata[`PWRT_FLAG_BIT] = s_nxt.mask;
				end
				`PWRT_IDX_TEST: begin
					s_nxt.hrdata[7:0] = s_nxt.test;
				end
				`PWRT_IDX_TEMP_TRIM: begin
					s_nxt.hrdata[`PWRT_TEMP_OE_BIT] = s_nxt.temp_oe;
					s_nxt.hrdata[`PWRT_TEMP_TRIM_MSB:0] = s_nxt.temp_trim;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s_r.st <= pwrt_pkg::PWRT_IDLE;
			s_r.gate_cnt <= 2'h0;
			s_r.cnt <= 18'h00000;
			s_r.aclk_d <= 1'b0;
			s_r.enable <= 1'b0;
			s_r.clksel <= `PWRT_RST_CLKSEL;
			s_r.rate <= `PWRT_RST_RATE;
			s_r.rc_trim <= `PWRT_RST_RC_TRIM;
			s_r.temp_oe <= 1'b0;
			s_r.temp_trim <= 4'h0;
			s_r.test <= `PWRT_RST_TEST;
			s_r.flag <= 1'b0;
			s_r.mask <= 1'b0;
			s_r.load_pend <= 1'b1;
			s_r.dp_wr <= 1'b0;
			s_r.dp_rd <= 1'b0;
			s_r.dp_idx <= 10'h000;
			s_r.hrdata <= 32'h00000000;
			s_r.hready <= 1'b1;
			s_r.irq <= 1'b0;
			s_r.tick <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Trim outputs drive the analog oscillator and the temperature sensor directly.
	assign rc_period_trim_field_o   = s_r.rc_trim;
	assign temp_offset_enable_o     = s_r.temp_oe;
	assign temp_offset_trim_field_o = s_r.temp_trim;
	assign test_o                   = s_r.test;
	assign periodic_timeout_o       = s_r.tick;
	assign irq_o                    = s_r.irq;
	assign hrdata_o                 = s_r.hrdata;
	assign hreadyout_o              = s_r.hready;
	assign hresp_o                  = 1'b0;

endmodule : pwrt_top

/* pwrt_defs.svh */
// Register map, field positions, reset values and timing counts of the periodic wakeup timer.
`ifndef PWRT_DEFS_SVH
`define PWRT_DEFS_SVH

// Register indices; the byte address is four times the index.
`define PWRT_IDX_CTRL        10'h2f0
`define PWRT_IDX_STATUS      10'h2f1
`define PWRT_IDX_RC_TRIM     10'h2f3
`define PWRT_IDX_RATE        10'h2f4
`define PWRT_IDX_MASK        10'h2f5
`define PWRT_IDX_TEST        10'h2f6
`define PWRT_IDX_TEMP_TRIM   10'h2f7
`define PWRT_IDX_W           10

// Control register fields.
`define PWRT_CTRL_CLKSEL_BIT 7
`define PWRT_CTRL_ENABLE_BIT 2

// Status and mask register fields.
`define PWRT_FLAG_BIT        0

// Trim register fields.
`define PWRT_RC_TRIM_MSB     7
`define PWRT_RC_TRIM_LSB     2
`define PWRT_TEMP_OE_BIT     7
`define PWRT_TEMP_TRIM_MSB   3

// Reset values.
`define PWRT_RST_RATE        16'h0000
`define PWRT_RST_RC_TRIM     6'h00
`define PWRT_RST_TEMP_TRIM   5'h00
`define PWRT_RST_TEST        8'h00
`define PWRT_RST_CLKSEL      1'b0

// Clock select encodings.
`define PWRT_SEL_RC          1'b0
`define PWRT_SEL_BUS         1'b1

// RC clock edges that the gate needs before the first counted edge.
`define PWRT_GATE_EDGES      2'h2

`endif

/* pwrt_pkg.sv */
// Types of the periodic wakeup timer.
package pwrt_pkg;

	typedef enum logic [1:0] {
		PWRT_IDLE,
		PWRT_GATE,
		PWRT_RUN
	} pwrt_state_e;

	typedef struct packed {
		pwrt_state_e st;
		logic [1:0]  gate_cnt;
		logic [17:0] cnt;
		logic        aclk_d;
		logic        enable;
		logic        clksel;
		logic [15:0] rate;
		logic [5:0]  rc_trim;
		logic        temp_oe;
		logic [3:0]  temp_trim;
		logic [7:0]  test;
		logic        flag;
		logic        mask;
		logic        load_pend;
		logic        dp_wr;
		logic        dp_rd;
		logic [9:0]  dp_idx;
		logic [31:0] hrdata;
		logic        hready;
		logic        irq;
		logic        tick;
	} pwrt_state_s;

endpackage : pwrt_pkg

/* pwrt_chk.sv */
// Port checker for the periodic wakeup timer.
`timescale 1ns/1ps
module pwrt_chk (
	input wire logic        mclk_i,
	input wire logic        rst_i,
	input wire logic        hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0]  htrans_i,
	input wire logic        hwrite_i,
	input wire logic        hready_i,
	input wire logic [31:0] hwdata_i,
	input wire logic        hreadyout_o,
	input wire logic        hresp_o,
	input wire logic        special_mode_i,
	input wire logic [5:0]  flash_rc_trim_i,
	input wire logic [7:0]  flash_temp_trim_i,
	input wire logic [5:0]  rc_period_trim_field_o,
	input wire logic        temp_offset_enable_o,
	input wire logic [7:0]  test_o,
	input wire logic        periodic_timeout_o,
	input wire logic        irq_o
);
	logic       wr_r;
	logic [9:0] idx_r;
	// Marks the data phase of a write so its hwdata can be tied to the register.
	always_ff @(posedge mclk_i) begin
		wr_r  <= !rst_i && hsel_i && htrans_i[1] && hready_i && hwrite_i;
		idx_r <= haddr_i[11:2];
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	sequence s_wr(logic [9:0] i);
		wr_r && idx_r == i;
	endsequence
	sequence s_rel;
		$past(rst_i) && !rst_i;
	endsequence
	a_resp_okay_ready: assert property (hresp_o == 1'b0 && hreadyout_o) else $error("bad bus answer");
	a_pulse_single: assert property (periodic_timeout_o |=> !periodic_timeout_o) else $error("long pulse");
	a_rc_trim_load: assert property (s_rel |=> rc_period_trim_field_o == $past(flash_rc_trim_i))
		else $error("rc trim not loaded");
	a_temp_trim_load: assert property (s_rel |=> temp_offset_enable_o == $past(flash_temp_trim_i[7]))
		else $error("temp trim not loaded");
	a_rc_trim_write: assert property (s_wr(10'h2f3) |=> rc_period_trim_field_o == $past(hwdata_i[7:2]))
		else $error("rc trim write lost");
	a_test_write_ok: assert property (s_wr(10'h2f6) ##0 special_mode_i |=> test_o == $past(hwdata_i[7:0]))
		else $error("test write lost");
	a_test_write_blk: assert property (s_wr(10'h2f6) ##0 !special_mode_i |=> $stable(test_o))
		else $error("test write taken");
	a_irq_sticky: assert property (irq_o && !wr_r |=> irq_o) else $error("irq dropped");
endmodule : pwrt_chk

bind pwrt_top pwrt_chk chk_u (.*);

/* pwrt_tb_top.sv */
// Self-checking bench for the periodic wakeup timer.
`timescale 1ns/1ps
module pwrt_tb_top;
	logic        mclk_i = 0, rst_i = 1, hsel_i = 0, hwrite_i = 0, special_mode_i = 0;
	logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, rd, d;
	logic [1:0]  htrans_i = 0, ac = 0;
	logic [2:0]  hsize_i = 3'h2;
	logic [5:0]  flash_rc_trim_i, rc_period_trim_field_o;
	logic [7:0]  flash_temp_trim_i, test_o;
	logic [3:0]  temp_offset_trim_field_o;
	logic        hreadyout_o, hresp_o, temp_offset_enable_o, periodic_timeout_o, irq_o;
	wire logic   hready_i = hreadyout_o;
	wire logic   aclk_i = ac[1];
	int          errors = 0, tests_run = 0, n, r;
	pwrt_top dut_u (.*);
	always #12.5 mclk_i = !mclk_i;
	// Slow clock with one rising edge every four bus cycles.
	always @(posedge mclk_i) ac <= ac + 2'h1;
	task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	task bus(input logic w, input logic [9:0] i, input logic [31:0] wd);
		@(posedge mclk_i);
		hsel_i   <= 1;
		htrans_i <= 2'h2;
		hwrite_i <= w;
		haddr_i  <= {20'h0, i, 2'h0};
		do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
		hsel_i   <= 0;
		htrans_i <= 0;
		hwdata_i <= wd;
		do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
	endtask : bus
	task gap(output int c);
		c = 0;
		while (periodic_timeout_o !== 1'b1) @(posedge mclk_i);
		do begin
			@(posedge mclk_i);
			c++;
		end while (periodic_timeout_o !== 1'b1);
	endtask : gap
	task end_of_test;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	initial begin
		#2000000;
		errors++;
		end_of_test;
	end
	initial begin
		r = $urandom(14063);
		flash_rc_trim_i = 6'($urandom);
		flash_temp_trim_i = 8'($urandom);
		d = $urandom;
		r = $urandom % 8;
		repeat (2) @(posedge mclk_i);
		rst_i <= 0;
		repeat (2) @(posedge mclk_i);
		chk("rc_trim", 32'(rc_period_trim_field_o), 32'(flash_rc_trim_i));
		chk("temp_oe", 32'(temp_offset_enable_o), 32'(flash_temp_trim_i[7]));
		chk("temp_trim", 32'(temp_offset_trim_field_o), 32'(flash_temp_trim_i[3:0]));
		bus(1, 10'h2f3, d);
		bus(0, 10'h2f3, 0);
		chk("rc_reg", rd, {24'h0, d[7:2], 2'h0});
		bus(1, 10'h2f7, d);
		bus(0, 10'h2f7, 0);
		chk("temp_reg", rd, d & 32'h8f);
		for (int m = 0; m < 2; m++) begin
			special_mode_i <= m[0];
			bus(1, 10'h2f6, ~d);
			bus(0, 10'h2f6, 0);
			chk("test_reg", rd, m[0] ? {24'h0, ~d[7:0]} : 32'h0);
		end
		special_mode_i <= 0;
		bus(0, 10'h2f2, 0);
		chk("unmapped", rd, 0);
		bus(1, 10'h2f4, 32'(r));
		bus(1, 10'h2f0, 32'h80);
		bus(1, 10'h2f5, 1);
		bus(1, 10'h2f0, 32'h84);
		bus(1, 10'h2f4, 32'hffff);
		gap(n);
		chk("bus_gap", 32'(n), 32'(2 * (r + 1)));
		bus(0, 10'h2f4, 0);
		chk("rate_lock", rd, 32'(r));
		bus(0, 10'h2f1, 0);
		chk("flag", rd, 1);
		chk("irq", 32'(irq_o), 1);
		bus(1, 10'h2f0, 32'h80);
		bus(1, 10'h2f1, 0);
		bus(0, 10'h2f1, 0);
		chk("flag_w0", rd, 1);
		bus(1, 10'h2f1, 1);
		repeat (40) @(posedge mclk_i);
		chk("stopped", 32'(irq_o), 0);
		bus(1, 10'h2f0, 32'h04);
		bus(0, 10'h2f0, 0);
		chk("clksel_lock", rd, 32'h84);
		bus(1, 10'h2f0, 0);
		bus(1, 10'h2f0, 0);
		bus(1, 10'h2f0, 32'h04);
		gap(n);
		chk("rc_gap", 32'(n), 32'(16 * (r + 1)));
		end_of_test;
	end
endmodule : pwrt_tb_top
